// ---- rtl/aog_pkg.sv ----
// Package for the adder operand gate control block: register map, fields, selection indices and gate constants.
package aog_pkg;
  localparam int unsigned AOG_WIDTH = 16;
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] AOG_OFS_CTRL   = 8'h00;
  localparam logic [7:0] AOG_OFS_STATUS = 8'h04;
  localparam logic [7:0] AOG_OFS_REGA   = 8'h08;
  localparam logic [7:0] AOG_OFS_REGY   = 8'h0c;
  localparam logic [7:0] AOG_OFS_REGX   = 8'h10;
  localparam logic [7:0] AOG_OFS_REGQ   = 8'h14;
  localparam logic [7:0] AOG_OFS_REGP   = 8'h18;
  localparam logic [7:0] AOG_OFS_MASK   = 8'h1c;
  localparam logic [7:0] AOG_OFS_BORROW = 8'h20;
  // Control register field positions.
  localparam int unsigned AOG_CTRL_BLOCK_INC = 0;
  localparam int unsigned AOG_CTRL_STOPPED   = 1;
  localparam int unsigned AOG_CTRL_DISP_LO   = 2;
  localparam int unsigned AOG_CTRL_DISP_HI   = 4;
  localparam int unsigned AOG_CTRL_W         = 5;
  localparam logic [AOG_CTRL_W-1:0] AOG_CTRL_RST = 5'h00;
  // X register bit that names the mask as origin of an inter-register move.
  localparam int unsigned AOG_X_MASK_BIT = 3;
  localparam logic [1:0] AOG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] AOG_RESP_SLVERR = 2'h2;
  // Manual display selection codes.
  typedef enum logic [2:0] {
    AOG_DISP_NONE = 3'h0,
    AOG_DISP_Q    = 3'h1,
    AOG_DISP_X    = 3'h2,
    AOG_DISP_P    = 3'h3,
    AOG_DISP_MASK = 3'h4
  } aog_disp_t;
  // Operand gate control flip-flop indices: augend 0..2, addend 3..6.
  localparam int unsigned AOG_NSEL       = 7;
  localparam int unsigned AOG_SEL_PLUS1  = 0;
  localparam int unsigned AOG_SEL_Y_AUG  = 1;
  localparam int unsigned AOG_SEL_X_AUG  = 2;
  localparam int unsigned AOG_SEL_Q_ADN  = 3;
  localparam int unsigned AOG_SEL_X_ADN  = 4;
  localparam int unsigned AOG_SEL_P_ADN  = 5;
  localparam int unsigned AOG_SEL_M_ADN  = 6;
  localparam logic [AOG_NSEL-1:0] AOG_SEL_RST = 7'h00;
  localparam logic [15:0] AOG_NEG_ZERO = 16'hffff;
  localparam logic [15:0] AOG_PLUS_ONE = 16'h0001;
endpackage : aog_pkg

// ---- rtl/aog_gate_ctrl.sv ----
// Adder operand gate control with AXI4-Lite register access.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module aog_gate_ctrl
  import aog_pkg::*;
#(
  parameter int unsigned WIDTH = AOG_WIDTH
) (
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  // Processor timing and decode inputs.
  input  wire logic              i_t00,
  input  wire logic              i_ph_h01,
  input  wire logic              i_ph_h05,
  input  wire logic              i_phase_end,
  input  wire logic              i_cyc_a,
  input  wire logic              i_cyc_b,
  input  wire logic              i_cyc_c,
  input  wire logic              i_addr_mode,
  input  wire logic              i_operand_read_mode,
  input  wire logic              i_store_mode,
  input  wire logic              i_reg_mode,
  input  wire logic              i_shift_cycle,
  input  wire logic              i_interrupt,
  input  wire logic              i_indirect,
  input  wire logic              i_q_index,
  input  wire logic              i_read_next_instruction,
  input  wire logic              i_disp_zero,
  input  wire logic              i_return_jump_op,
  input  wire logic              i_exit_interrupt_op,
  input  wire logic              i_multiply_op,
  input  wire logic              i_divide_op,
  input  wire logic              i_mult_step,
  input  wire logic              i_multiplier_bit,
  input  wire logic              i_inter_register_op,
  // Pyramid borrow terms.
  input  wire logic              i_sec0_borrow,
  input  wire logic              i_sec1_borrow,
  input  wire logic              i_sec1_enable,
  input  wire logic              i_stage15_borrow,
  input  wire logic              i_stage15_enable,
  // AXI4-Lite slave.
  input  wire logic [7:0]        i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [7:0]        i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  // Adder gate outputs.
  output logic [WIDTH-1:0]       o_augend_gate,
  output logic [WIDTH-1:0]       o_addend_gate,
  output logic [AOG_NSEL-1:0]    o_sel_n,
  output logic                   o_group0_borrow,
  output logic                   o_end_around_borrow
);

  // The gate constants and the register map are fixed at sixteen bits.
  if (WIDTH != 16) begin : g_width_check
    $error("aog_gate_ctrl supports only a 16-bit adder");
  end

  typedef struct packed {
    logic [AOG_NSEL-1:0]   sel;
    logic [AOG_CTRL_W-1:0] ctrl;
    logic [WIDTH-1:0]      ra;
    logic [WIDTH-1:0]      ry;
    logic [WIDTH-1:0]      rx;
    logic [WIDTH-1:0]      rq;
    logic [WIDTH-1:0]      rp;
    logic [WIDTH-1:0]      rm;
    logic [WIDTH-1:0]      augend_gate;
    logic [WIDTH-1:0]      addend_gate;
    logic                  g0b;
    logic                  eab;
    logic                  aw_got;
    logic [7:0]            aw_addr;
    logic                  w_got;
    logic [31:0]           w_data;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } aog_state_t;

  aog_state_t st_r;
  aog_state_t st_nxt;

  logic       first_timing_phase;
  logic       third_timing_phase;
  logic [2:0] disp;
  logic       stopped;
  logic       wr_go;
  logic       rd_go;
  logic       rnz;

  assign first_timing_phase    = i_t00 & i_ph_h01;
  assign third_timing_phase    = i_t00 & i_ph_h05;
  assign stopped = st_r.ctrl[AOG_CTRL_STOPPED];
  assign disp    = st_r.ctrl[AOG_CTRL_DISP_HI:AOG_CTRL_DISP_LO];
  assign rnz     = i_read_next_instruction & i_disp_zero;
  assign wr_go   = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
  assign rd_go   = i_arvalid & ~st_r.rvalid;

  always_comb begin
    logic [AOG_NSEL-1:0] set;
    logic [WIDTH-1:0]    a;
    logic [WIDTH-1:0]    d;
    set    = '0;
    a      = AOG_NEG_ZERO;
    d      = AOG_NEG_ZERO;
    st_nxt = st_r;
    if (stopped) begin
      if (i_t00) begin
        case (disp)
          AOG_DISP_Q:    set[AOG_SEL_Q_ADN] = 1'b1;
          AOG_DISP_X:    set[AOG_SEL_X_ADN] = 1'b1;
          AOG_DISP_P:    set[AOG_SEL_P_ADN] = 1'b1;
          AOG_DISP_MASK: set[AOG_SEL_M_ADN] = 1'b1;
          default:       set = '0;
        endcase
      end
    end else if (first_timing_phase) begin
      if (i_cyc_b & i_addr_mode & i_return_jump_op) begin
        set[AOG_SEL_PLUS1] = 1'b1;
      end
      if (i_cyc_a & i_inter_register_op & st_r.rx[AOG_X_MASK_BIT]) begin
        set[AOG_SEL_M_ADN] = 1'b1;
      end else if (i_cyc_a & (i_operand_read_mode | (i_addr_mode & ~rnz))) begin
        set[AOG_SEL_X_ADN] = 1'b1;
      end
    end else if (third_timing_phase) begin
      if (i_cyc_a & i_addr_mode & i_indirect & i_q_index) begin
        set[AOG_SEL_Y_AUG] = 1'b1;
        if (~i_interrupt & (~i_read_next_instruction | i_disp_zero)) begin
          set[AOG_SEL_Q_ADN] = 1'b1;
        end
      end
      if (i_cyc_c & i_mult_step & i_multiplier_bit) begin
        set[AOG_SEL_X_AUG] = 1'b1;
      end
      if ((i_multiply_op | i_divide_op) &
          ((i_cyc_a & i_operand_read_mode) | (i_cyc_c & i_mult_step))) begin
        set[AOG_SEL_Q_ADN] = 1'b1;
      end else if (i_cyc_a & i_operand_read_mode & ~i_exit_interrupt_op) begin
        set[AOG_SEL_P_ADN] = 1'b1;
        set[AOG_SEL_PLUS1] = 1'b1;
      end else if (i_cyc_a & (i_store_mode | (i_reg_mode & ~i_shift_cycle))) begin
        set[AOG_SEL_P_ADN] = 1'b1;
      end
    end
    if (st_r.ctrl[AOG_CTRL_BLOCK_INC]) begin
      set[AOG_SEL_PLUS1] = 1'b0;
    end
    // Priority keeps a single addend source even when decodes overlap.
    if (set[AOG_SEL_Q_ADN]) begin
      set[AOG_SEL_P_ADN:AOG_SEL_X_ADN] = '0;
      set[AOG_SEL_M_ADN] = 1'b0;
    end else if (set[AOG_SEL_M_ADN]) begin
      set[AOG_SEL_P_ADN:AOG_SEL_X_ADN] = '0;
    end else if (set[AOG_SEL_P_ADN]) begin
      set[AOG_SEL_X_ADN] = 1'b0;
    end
    if (|set) begin
      st_nxt.sel = set;
    end else if (i_phase_end) begin
      st_nxt.sel = AOG_SEL_RST;
    end
    // Gates follow the latched selection; an empty side gives negative zero.
    if (st_nxt.sel[AOG_SEL_PLUS1]) begin
      a = AOG_PLUS_ONE;
    end else if (st_nxt.sel[AOG_SEL_Y_AUG]) begin
      a = st_r.ry;
    end else if (st_nxt.sel[AOG_SEL_X_AUG]) begin
      a = st_r.rx;
    end
    if (st_nxt.sel[AOG_SEL_Q_ADN]) begin
      d = st_r.rq;
    end else if (st_nxt.sel[AOG_SEL_X_ADN]) begin
      d = st_r.rx;
    end else if (st_nxt.sel[AOG_SEL_P_ADN]) begin
      d = st_r.rp;
    end else if (st_nxt.sel[AOG_SEL_M_ADN]) begin
      d = st_r.rm;
    end
    st_nxt.augend_gate = a;
    st_nxt.addend_gate = d;
    st_nxt.g0b = i_sec1_borrow | (i_sec0_borrow & i_sec1_enable);
    st_nxt.eab = i_stage15_borrow | (i_stage15_enable & st_nxt.g0b);
    // AXI4-Lite write path.
    if (i_awvalid & ~st_r.aw_got) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = i_awaddr;
    end
    if (i_wvalid & ~st_r.w_got) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = i_wdata;
    end
    if (wr_go) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = AOG_RESP_OKAY;
      case (st_r.aw_addr)
        AOG_OFS_CTRL:   st_nxt.ctrl = st_r.w_data[AOG_CTRL_W-1:0];
        AOG_OFS_REGA:   st_nxt.ra   = st_r.w_data[WIDTH-1:0];
        AOG_OFS_REGY:   st_nxt.ry   = st_r.w_data[WIDTH-1:0];
        AOG_OFS_REGX:   st_nxt.rx   = st_r.w_data[WIDTH-1:0];
        AOG_OFS_REGQ:   st_nxt.rq   = st_r.w_data[WIDTH-1:0];
        AOG_OFS_REGP:   st_nxt.rp   = st_r.w_data[WIDTH-1:0];
        AOG_OFS_MASK:   st_nxt.rm   = st_r.w_data[WIDTH-1:0];
        default:        st_nxt.bresp = AOG_RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid & i_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    // AXI4-Lite read path.
    if (rd_go) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = AOG_RESP_OKAY;
      st_nxt.rdata  = 32'h0000_0000;
      case (i_araddr)
        AOG_OFS_CTRL:   st_nxt.rdata[AOG_CTRL_W-1:0] = st_r.ctrl;
        AOG_OFS_STATUS: st_nxt.rdata[AOG_NSEL-1:0]   = st_r.sel;
        AOG_OFS_REGA:   st_nxt.rdata[WIDTH-1:0]      = st_r.ra;
        AOG_OFS_REGY:   st_nxt.rdata[WIDTH-1:0]      = st_r.ry;
        AOG_OFS_REGX:   st_nxt.rdata[WIDTH-1:0]      = st_r.rx;
        AOG_OFS_REGQ:   st_nxt.rdata[WIDTH-1:0]      = st_r.rq;
        AOG_OFS_REGP:   st_nxt.rdata[WIDTH-1:0]      = st_r.rp;
        AOG_OFS_MASK:   st_nxt.rdata[WIDTH-1:0]      = st_r.rm;
        AOG_OFS_BORROW: st_nxt.rdata[1:0]            = {st_r.eab, st_r.g0b};
        default:        st_nxt.rresp = AOG_RESP_SLVERR;
      endcase
    end else if (st_r.rvalid & i_rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r      <= '0;
      st_r.ctrl <= AOG_CTRL_RST;
      st_r.sel  <= AOG_SEL_RST;
      st_r.augend_gate  <= AOG_NEG_ZERO;
      st_r.addend_gate  <= AOG_NEG_ZERO;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_augend_gate       = st_r.augend_gate;
  assign o_addend_gate       = st_r.addend_gate;
  assign o_sel_n             = ~st_r.sel;
  assign o_group0_borrow     = st_r.g0b;
  assign o_end_around_borrow = st_r.eab;
  assign o_awready           = ~st_r.aw_got;
  assign o_wready            = ~st_r.w_got;
  assign o_bvalid            = st_r.bvalid;
  assign o_bresp             = st_r.bresp;
  assign o_arready           = ~st_r.rvalid;
  assign o_rvalid            = st_r.rvalid;
  assign o_rdata             = st_r.rdata;
  assign o_rresp             = st_r.rresp;

  sequence s_timing_pulse;
    i_t00 && (i_ph_h01 || i_ph_h05 || stopped);
  endsequence

  // Running phases only; the stopped display path has a property of its own.
  sequence s_first_phase;
    !stopped && first_timing_phase;
  endsequence

  sequence s_third_phase;
    !stopped && third_timing_phase;
  endsequence

  a_addend_onehot: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $onehot0(st_r.sel[AOG_SEL_M_ADN:AOG_SEL_Q_ADN]))
    else $error("more than one addend source selected");
  a_set_timing: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ($rose(|st_r.sel) |-> $past(i_t00)))
    else $error("gate control set outside a timing pulse");
  a_block_inc: assert property (@(posedge i_clk) disable iff (!i_rstn)
    ((st_r.ctrl[AOG_CTRL_BLOCK_INC] and s_timing_pulse) |=> !$rose(st_r.sel[AOG_SEL_PLUS1])))
    else $error("plus one set while increment blocked");
  a_plus_one_val: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (st_r.sel[AOG_SEL_PLUS1] |-> o_augend_gate == AOG_PLUS_ONE))
    else $error("plus one selection not giving one");
  a_aug_neg_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (st_r.sel[AOG_SEL_X_AUG:AOG_SEL_PLUS1] == '0 |-> o_augend_gate == AOG_NEG_ZERO))
    else $error("empty augend side not negative zero");
  a_adn_neg_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (st_r.sel[AOG_SEL_M_ADN:AOG_SEL_Q_ADN] == '0 |-> o_addend_gate == AOG_NEG_ZERO))
    else $error("empty addend side not negative zero");
  a_group0_borrow: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (1'b1 |=> o_group0_borrow == ($past(i_sec1_borrow) ||
     ($past(i_sec0_borrow) && $past(i_sec1_enable)))))
    else $error("group 0 borrow mismatch");
  a_eab_form: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (1'b1 |=> o_end_around_borrow == ($past(i_stage15_borrow) ||
     ($past(i_stage15_enable) && o_group0_borrow))))
    else $error("end around borrow mismatch");
  a_phase_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_phase_end && !i_t00 |=> st_r.sel == '0))
    else $error("selection not cleared at phase end");
  a_sel_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (!i_t00 && !i_phase_end |=> $stable(st_r.sel)))
    else $error("selection changed outside a pulse or phase end");
  a_ret_jump: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_first_phase ##0 (i_cyc_b && i_addr_mode && i_return_jump_op
     && !st_r.ctrl[AOG_CTRL_BLOCK_INC]) |=> st_r.sel[AOG_SEL_PLUS1]))
    else $error("return jump did not set plus one");
  a_index_y_aug: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_third_phase ##0 (i_cyc_a && i_addr_mode && i_indirect && i_q_index)
     |=> st_r.sel[AOG_SEL_Y_AUG]))
    else $error("indexed address did not select Y on the augend");
  a_index_q_adn: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_third_phase ##0 (i_cyc_a && i_addr_mode && i_indirect && i_q_index && !i_interrupt
     && (!i_read_next_instruction || i_disp_zero)) |=> st_r.sel[AOG_SEL_Q_ADN]))
    else $error("indexed address did not select Q on the addend");
  a_mult_step: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_third_phase ##0 (i_cyc_c && i_multiply_op && i_mult_step && i_multiplier_bit)
     |=> st_r.sel[AOG_SEL_X_AUG] && st_r.sel[AOG_SEL_Q_ADN]))
    else $error("multiply step did not add X and Q");
  a_read_x_adn: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_first_phase ##0 (i_cyc_a && i_operand_read_mode
     && !(i_inter_register_op && st_r.rx[AOG_X_MASK_BIT])) |=> st_r.sel[AOG_SEL_X_ADN]))
    else $error("operand read did not select X on the addend");
  a_mask_adn: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_first_phase ##0 (i_cyc_a && i_inter_register_op && st_r.rx[AOG_X_MASK_BIT])
     |=> st_r.sel[AOG_SEL_M_ADN]))
    else $error("inter-register move did not select the mask");
  a_next_addr: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_third_phase ##0 (i_cyc_a && i_operand_read_mode && !i_addr_mode && !i_multiply_op
     && !i_divide_op && !i_exit_interrupt_op && !st_r.ctrl[AOG_CTRL_BLOCK_INC])
     |=> st_r.sel[AOG_SEL_P_ADN] && st_r.sel[AOG_SEL_PLUS1]))
    else $error("next sequential address not formed");
  a_store_p: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (s_third_phase ##0 (i_cyc_a && (i_store_mode || (i_reg_mode && !i_shift_cycle))
     && !i_operand_read_mode && !i_addr_mode && !i_mult_step) |=> st_r.sel[AOG_SEL_P_ADN]))
    else $error("store or register mode did not select P");
  a_display_sel: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (stopped && i_t00 && disp == AOG_DISP_Q |=> st_r.sel[AOG_SEL_Q_ADN]))
    else $error("manual display of Q not selected");

endmodule : aog_gate_ctrl

// ---- verification/aog_pyr_model.sv ----
// Behavioural model of the adder pyramid that feeds borrow and enable terms back.
`timescale 1ns/10ps
module aog_pyr_model (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic [4:0] i_pat,
  output logic            o_sec0_borrow,
  output logic            o_sec1_borrow,
  output logic            o_sec1_enable,
  output logic            o_stage15_borrow,
  output logic            o_stage15_enable
);
  // Terms come from flops, since pyramid outputs settle one cycle after the operands.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      {o_stage15_enable, o_stage15_borrow, o_sec1_enable, o_sec1_borrow, o_sec0_borrow} <= 5'h00;
    end else begin
      {o_stage15_enable, o_stage15_borrow, o_sec1_enable, o_sec1_borrow, o_sec0_borrow} <= i_pat;
    end
  end
endmodule : aog_pyr_model

// ---- verification/aog_gate_ctrl_tb_top.sv ----
// Self-checking bench for the adder operand gate control block.
`timescale 1ns/10ps
module aog_gate_ctrl_tb_top;
  import aog_pkg::*;
  localparam logic [15:0] RY = 16'h2345;
  localparam logic [15:0] RX = 16'h0c58;
  localparam logic [15:0] RQ = 16'h1234;
  localparam logic [15:0] RP = 16'h0100;
  localparam logic [15:0] RM = 16'h00f0;
  localparam logic [15:0] DV [4] = '{RQ, RX, RP, RM};
  logic        i_clk, i_rstn, i_t00, i_ph_h01, i_ph_h05, i_phase_end, g;
  logic [19:0] dec;
  logic [4:0]  pat;
  logic        s0b, s1b, s1e, s15b, s15e;
  logic [7:0]  i_awaddr, i_araddr;
  logic        i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0]  i_wstrb;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic        o_group0_borrow, o_end_around_borrow;
  logic [1:0]  o_bresp, o_rresp;
  logic [15:0] o_augend_gate, o_addend_gate;
  logic [AOG_NSEL-1:0] o_sel_n;
  int          miscompares, n_checks;

  aog_pyr_model u_pyr (.i_clk, .i_rstn, .i_pat(pat), .o_sec0_borrow(s0b), .o_sec1_borrow(s1b),
    .o_sec1_enable(s1e), .o_stage15_borrow(s15b), .o_stage15_enable(s15e));

  // Decode vector bits: 0 A, 1 B, 2 C cycle, 3 address, 4 operand read, 5 store, 6 register,
  // 7 shift, 8 interrupt, 9 indirect, 10 q index, 11 read next, 12 zero displacement,
  // 13 return jump, 14 exit interrupt, 15 multiply, 16 divide, 17 step, 18 bit, 19 inter reg.
  aog_gate_ctrl u_dut (.i_clk, .i_rstn, .i_t00, .i_ph_h01, .i_ph_h05, .i_phase_end,
    .i_cyc_a(dec[0]), .i_cyc_b(dec[1]), .i_cyc_c(dec[2]), .i_addr_mode(dec[3]),
    .i_operand_read_mode(dec[4]), .i_store_mode(dec[5]), .i_reg_mode(dec[6]),
    .i_shift_cycle(dec[7]), .i_interrupt(dec[8]), .i_indirect(dec[9]), .i_q_index(dec[10]),
    .i_read_next_instruction(dec[11]), .i_disp_zero(dec[12]), .i_return_jump_op(dec[13]),
    .i_exit_interrupt_op(dec[14]), .i_multiply_op(dec[15]), .i_divide_op(dec[16]),
    .i_mult_step(dec[17]), .i_multiplier_bit(dec[18]), .i_inter_register_op(dec[19]),
    .i_sec0_borrow(s0b), .i_sec1_borrow(s1b), .i_sec1_enable(s1e),
    .i_stage15_borrow(s15b), .i_stage15_enable(s15e),
    .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp,
    .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready, .o_augend_gate, .o_addend_gate, .o_sel_n, .o_group0_borrow,
    .o_end_around_borrow);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks=%0d mismatches=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge i_clk);
    i_awaddr  <= a;
    i_wdata   <= d;
    i_awvalid <= 1'b1;
    i_wvalid  <= 1'b1;
    i_bready  <= 1'b1;
    while (!done) begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid === 1'b1) begin
        done = 1'b1;
        i_bready <= 1'b0;
        chk(32'(o_bresp), 32'(er));
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge i_clk);
    i_araddr  <= a;
    i_arvalid <= 1'b1;
    i_rready  <= 1'b1;
    while (!done) begin
      @(posedge i_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid === 1'b1) begin
        done = 1'b1;
        i_rready <= 1'b0;
        chk(o_rdata, ed);
        chk(32'(o_rresp), 32'(er));
      end
    end
  endtask : rd

  // One timing pulse {t00, h01, h05} with a decode, a check of the selection, then phase end.
  task automatic phs(input logic [2:0] tp, input logic [19:0] d, input logic [6:0] es,
                     input logic [15:0] eu, input logic [15:0] ea);
    @(posedge i_clk);
    {i_t00, i_ph_h01, i_ph_h05} <= tp;
    dec <= d;
    @(posedge i_clk);
    {i_t00, i_ph_h01, i_ph_h05} <= 3'h0;
    dec <= 20'h0;
    #1;
    chk(32'(o_sel_n), 32'(es));
    chk(32'(o_augend_gate), 32'(eu));
    chk(32'(o_addend_gate), 32'(ea));
    @(posedge i_clk);
    i_phase_end <= 1'b1;
    @(posedge i_clk);
    i_phase_end <= 1'b0;
    #1;
    chk(32'(o_sel_n), 32'h7f);
    chk(32'(o_augend_gate), 32'(AOG_NEG_ZERO));
    chk(32'(o_addend_gate), 32'(AOG_NEG_ZERO));
  endtask : phs

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    results();
  end

  initial begin
    {i_rstn, i_t00, i_ph_h01, i_ph_h05, i_phase_end, dec, pat} = '0;
    {i_awaddr, i_araddr, i_wdata, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    i_wstrb = 4'hf;
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    #1;
    chk(32'(o_sel_n), 32'h7f);
    chk(32'(o_augend_gate), 32'(AOG_NEG_ZERO));
    chk(32'(o_addend_gate), 32'(AOG_NEG_ZERO));
    wr(AOG_OFS_REGY, 32'(RY), AOG_RESP_OKAY);
    wr(AOG_OFS_REGX, 32'(RX), AOG_RESP_OKAY);
    wr(AOG_OFS_REGQ, 32'(RQ), AOG_RESP_OKAY);
    wr(AOG_OFS_REGP, 32'(RP), AOG_RESP_OKAY);
    wr(AOG_OFS_MASK, 32'(RM), AOG_RESP_OKAY);
    rd(AOG_OFS_REGY, 32'(RY), AOG_RESP_OKAY);
    wr(AOG_OFS_REGA, 32'h0000abcd, AOG_RESP_OKAY);
    rd(AOG_OFS_REGA, 32'h0000abcd, AOG_RESP_OKAY);
    rd(AOG_OFS_STATUS, 32'h0, AOG_RESP_OKAY);
    rd(8'h24, 32'h0, AOG_RESP_SLVERR);
    wr(AOG_OFS_STATUS, 32'h1, AOG_RESP_SLVERR);
    wr(AOG_OFS_BORROW, 32'h1, AOG_RESP_SLVERR);
    $display("test registers done");
    phs(3'h5, 20'h00011, 7'h5e, AOG_PLUS_ONE, RP);
    wr(AOG_OFS_CTRL, 32'h1, AOG_RESP_OKAY);
    phs(3'h5, 20'h00011, 7'h5f, AOG_NEG_ZERO, RP);
    wr(AOG_OFS_CTRL, 32'h0, AOG_RESP_OKAY);
    phs(3'h6, 20'h00011, 7'h6f, AOG_NEG_ZERO, RX);
    phs(3'h6, 20'h0200a, 7'h7e, AOG_PLUS_ONE, AOG_NEG_ZERO);
    phs(3'h6, 20'h00009, 7'h6f, AOG_NEG_ZERO, RX);
    phs(3'h5, 20'h00609, 7'h75, RY, RQ);
    phs(3'h5, 20'h08011, 7'h77, AOG_NEG_ZERO, RQ);
    phs(3'h5, 20'h68004, 7'h73, RX, RQ);
    phs(3'h5, 20'h00021, 7'h5f, AOG_NEG_ZERO, RP);
    phs(3'h5, 20'h00041, 7'h5f, AOG_NEG_ZERO, RP);
    phs(3'h5, 20'h000c1, 7'h7f, AOG_NEG_ZERO, AOG_NEG_ZERO);
    phs(3'h6, 20'h80001, 7'h3f, AOG_NEG_ZERO, RM);
    phs(3'h6, 20'h80011, 7'h3f, AOG_NEG_ZERO, RM);
    phs(3'h1, 20'h00011, 7'h7f, AOG_NEG_ZERO, AOG_NEG_ZERO);
    phs(3'h4, 20'h00011, 7'h7f, AOG_NEG_ZERO, AOG_NEG_ZERO);
    phs(3'h5, 20'h04011, 7'h7f, AOG_NEG_ZERO, AOG_NEG_ZERO);
    phs(3'h5, 20'h10011, 7'h77, AOG_NEG_ZERO, RQ);
    phs(3'h5, 20'h00709, 7'h7d, RY, AOG_NEG_ZERO);
    phs(3'h5, 20'h00e09, 7'h7d, RY, AOG_NEG_ZERO);
    phs(3'h5, 20'h01e09, 7'h75, RY, RQ);
    phs(3'h6, 20'h01809, 7'h7f, AOG_NEG_ZERO, AOG_NEG_ZERO);
    $display("test gate selection done");
    for (int k = 1; k <= 4; k++) begin
      wr(AOG_OFS_CTRL, 32'(2 + 4 * k), AOG_RESP_OKAY);
      rd(AOG_OFS_CTRL, 32'(2 + 4 * k), AOG_RESP_OKAY);
      phs(3'h4, 20'h0, 7'h7f ^ (7'h04 << k), AOG_NEG_ZERO, DV[k-1]);
    end
    wr(AOG_OFS_CTRL, 32'h0, AOG_RESP_OKAY);
    $display("test manual display done");
    for (int p = 0; p < 32; p++) begin
      @(posedge i_clk);
      pat <= 5'(p);
      repeat (3) @(posedge i_clk);
      #1;
      g = pat[1] | (pat[0] & pat[2]);
      chk(32'(o_group0_borrow), 32'(g));
      chk(32'(o_end_around_borrow), 32'(pat[3] | (pat[4] & g)));
    end
    rd(AOG_OFS_BORROW, 32'h3, AOG_RESP_OKAY);
    $display("test borrow terms done");
    results();
  end
endmodule : aog_gate_ctrl_tb_top
